// File: core/scp_map.svh
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// Opcodes
`define SCP_OP_RDREG 3'h0
`define SCP_OP_RDBUF 3'h1
`define SCP_OP_WRREG 3'h2
`define SCP_OP_WRBUF 3'h3
`define SCP_OP_SETB 3'h4
`define SCP_OP_CLRB 3'h5
`define SCP_OP_SRST 3'h7
// Fixed arguments
`define SCP_BUF_ARG 5'h1a
`define SCP_RST_ARG 5'h1f
// Header field positions
`define SCP_OP_MSB 7
`define SCP_OP_LSB 5
`define SCP_ARG_MSB 4
`define SCP_ARG_LSB 0
// Buffer pointer width and limits
`define SCP_PTR_W 13
`define SCP_PTR_LAST 13'h1fff
`define SCP_PTR_ZERO 13'h0000
`define SCP_PTR_ONE 13'h0001
// Bit counter, reset and dummy read byte values
`define SCP_LAST_BIT 3'h7
`define SCP_BYTE_ZERO 8'h00
`define SCP_DUMMY_BYTE 8'h00
`endif

// File: core/scp_pkg.sv
package scp_pkg;

  // Pins sampled from the host side
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } scp_pins_t;

  // Buffer memory write request
  typedef struct packed {
    logic wr;
    logic [12:0] addr;
    logic [7:0] data;
  } scp_mem_wr_t;

  // Control register write request
  typedef struct packed {
    logic wr;
    logic [4:0] addr;
    logic [7:0] data;
  } scp_reg_wr_t;

  // Frame states
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_HDR   = 9'h002,
    ST_RDREG = 9'h004,
    ST_RDBUF = 9'h008,
    ST_WRREG = 9'h010,
    ST_WRBUF = 9'h020,
    ST_SETB  = 9'h040,
    ST_CLRB  = 9'h080,
    ST_SKIP  = 9'h100
  } scp_state_t;

endpackage

// File: core/scp_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser with edge flags taken after the second stage
module scp_sync #(
  parameter int W = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // First stage feeds only the second stage
      always_ff @(posedge clock) begin
        if (rst) begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
          prev_reg[i] <= 1'b0;
        end else begin
          meta_reg[i] <= din[i];
          sync_reg[i] <= meta_reg[i];
          prev_reg[i] <= sync_reg[i];
        end
      end
      assign rise[i] = sync_reg[i] & ~prev_reg[i];
      assign fall[i] = ~sync_reg[i] & prev_reg[i];
    end
  endgenerate

  assign dout = sync_reg;

endmodule

// File: core/scp_spi_command_port.sv
`timescale 1ns/100ps
`include "scp_map.svh"
module scp_spi_command_port (
  input wire logic clock,
  input wire logic rst,
  input wire scp_pkg::scp_pins_t pins,
  output logic so_out,
  output logic so_oe,
  input wire logic pointer_auto_step,
  input wire logic [12:0] rx_ring_start,
  input wire logic [12:0] rx_ring_end,
  input wire logic rd_ptr_load,
  input wire logic wr_ptr_load,
  input wire logic [12:0] ptr_load_value,
  input wire logic reg_core_sel,
  input wire logic [7:0] reg_rdata,
  output scp_pkg::scp_reg_wr_t reg_req,
  output logic [12:0] buffer_read_pointer,
  output logic [12:0] buffer_write_pointer,
  input wire logic [7:0] mem_rdata,
  output scp_pkg::scp_mem_wr_t mem_req,
  output logic soft_reset_pulse
);

  // ------------------------------------------------------------
  // Pin sampling
  // ------------------------------------------------------------

  logic [2:0] pin_s;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  // Every pin crosses two flops; sck edges come from the synced level.
  // Select is synced active high, so the flops' reset value means deselected
  // and no false frame follows reset.
  scp_sync #(
    .W(3)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .din({~pins.cs_n, pins.sck, pins.si}),
    .dout(pin_s),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  logic si_s;
  logic sck_rise;
  logic sck_fall;
  logic frame;

  // Mode 0,0 only: data in on the rise, out on the fall
  assign si_s = pin_s[0];
  assign sck_rise = pin_rise[1];
  assign sck_fall = pin_fall[1];
  assign frame = pin_s[2];

  // ------------------------------------------------------------
  // Header decoding
  // ------------------------------------------------------------

  // Maps a header byte to the state that serves its payload
  function automatic scp_pkg::scp_state_t decode_hdr(input logic [7:0] hdr);
    logic [2:0] op;
    logic [4:0] arg;
    op = hdr[`SCP_OP_MSB:`SCP_OP_LSB];
    arg = hdr[`SCP_ARG_MSB:`SCP_ARG_LSB];
    case (op)
      `SCP_OP_RDREG: decode_hdr = scp_pkg::ST_RDREG;
      `SCP_OP_RDBUF: decode_hdr = (arg == `SCP_BUF_ARG) ? scp_pkg::ST_RDBUF : scp_pkg::ST_SKIP;
      `SCP_OP_WRREG: decode_hdr = scp_pkg::ST_WRREG;
      `SCP_OP_WRBUF: decode_hdr = (arg == `SCP_BUF_ARG) ? scp_pkg::ST_WRBUF : scp_pkg::ST_SKIP;
      `SCP_OP_SETB: decode_hdr = scp_pkg::ST_SETB;
      `SCP_OP_CLRB: decode_hdr = scp_pkg::ST_CLRB;
      default: decode_hdr = scp_pkg::ST_SKIP;
    endcase
  endfunction

  // Soft reset needs the exact constant as well as the opcode
  function automatic logic is_srst(input logic [7:0] hdr);
    is_srst = (hdr[`SCP_OP_MSB:`SCP_OP_LSB] == `SCP_OP_SRST) &&
              (hdr[`SCP_ARG_MSB:`SCP_ARG_LSB] == `SCP_RST_ARG);
  endfunction

  // ------------------------------------------------------------
  // Bit framing
  // ------------------------------------------------------------

  scp_pkg::scp_state_t state_reg;
  scp_pkg::scp_state_t state_next;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] byte_in;
  logic byte_done;
  logic hdr_done;

  // A byte counts only once its eighth bit has arrived
  assign byte_in = {shift_reg[6:0], si_s};
  assign byte_done = frame & sck_rise & (bit_cnt_reg == `SCP_LAST_BIT);
  assign hdr_done = byte_done & (state_reg == scp_pkg::ST_HDR);

  // Bit counter and input shifter restart on every deselect
  always_ff @(posedge clock) begin
    if (rst || !frame) begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= `SCP_BYTE_ZERO;
    end else if (sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg <= byte_in;
    end
  end

  // Deselect always wins, so any operation ends with chip select
  always_comb begin
    state_next = state_reg;
    if (!frame) begin
      state_next = scp_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        scp_pkg::ST_IDLE: state_next = scp_pkg::ST_HDR;
        scp_pkg::ST_HDR: begin
          if (byte_done) begin
            state_next = decode_hdr(byte_in);
          end
        end
        scp_pkg::ST_RDREG, scp_pkg::ST_RDBUF, scp_pkg::ST_WRREG, scp_pkg::ST_WRBUF,
        scp_pkg::ST_SETB, scp_pkg::ST_CLRB, scp_pkg::ST_SKIP: state_next = state_reg;
        default: state_next = scp_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= scp_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------

  logic reading;
  logic load_req_reg;
  logic first_load_reg;
  logic [7:0] tx_reg;
  logic [7:0] tx_src;
  logic so_reg;
  logic so_oe_reg;

  assign reading = (state_reg == scp_pkg::ST_RDREG) || (state_reg == scp_pkg::ST_RDBUF);

  // Byte chosen one clock after the header or data byte ends, so the
  // register address and read pointer have already settled
  assign tx_src = (state_reg == scp_pkg::ST_RDBUF) ? mem_rdata :
                  (first_load_reg && !reg_core_sel) ? `SCP_DUMMY_BYTE :
                  reg_rdata;

  // Reload request after each full byte keeps the stream going
  always_ff @(posedge clock) begin
    if (rst || !frame) begin
      load_req_reg <= 1'b0;
    end else begin
      load_req_reg <= byte_done &&
                      (reading || (hdr_done && (decode_hdr(byte_in) == scp_pkg::ST_RDREG ||
                                                decode_hdr(byte_in) == scp_pkg::ST_RDBUF)));
    end
  end

  // Dummy byte only once per non-core register read; buffer and core register reads get none
  always_ff @(posedge clock) begin
    if (rst || !frame) begin
      first_load_reg <= 1'b0;
    end else if (hdr_done) begin
      first_load_reg <= 1'b1;
    end else if (load_req_reg) begin
      first_load_reg <= 1'b0;
    end
  end

  // Output shifter: MSb leaves on the falling edge after the load
  always_ff @(posedge clock) begin
    if (rst || !frame) begin
      tx_reg <= `SCP_BYTE_ZERO;
      so_reg <= 1'b0;
    end else if (load_req_reg) begin
      tx_reg <= tx_src;
    end else if (sck_fall && reading) begin
      so_reg <= tx_reg[7];
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  // Drive the pin only while a read streams data
  always_ff @(posedge clock) begin
    if (rst) begin
      so_oe_reg <= 1'b0;
    end else begin
      so_oe_reg <= frame && reading;
    end
  end

  assign so_out = so_reg;
  assign so_oe = so_oe_reg;

  // ------------------------------------------------------------
  // Register writes and bit operations
  // ------------------------------------------------------------

  logic [7:0] wr_val;
  logic wr_fire;

  // Read-modify-write uses the addressed value on the last bit's edge
  assign wr_val = (state_reg == scp_pkg::ST_SETB) ? (reg_rdata | byte_in) :
                  (state_reg == scp_pkg::ST_CLRB) ? (reg_rdata & ~byte_in) :
                  byte_in;
  // Bit operations on non-core locations are dropped
  assign wr_fire = byte_done && ((state_reg == scp_pkg::ST_WRREG) ||
                   (reg_core_sel && ((state_reg == scp_pkg::ST_SETB) ||
                                     (state_reg == scp_pkg::ST_CLRB))));

  // Address latched from the header for the whole frame
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_req <= '0;
    end else begin
      reg_req.wr <= wr_fire;
      if (hdr_done) begin
        reg_req.addr <= byte_in[`SCP_ARG_MSB:`SCP_ARG_LSB];
      end
      if (wr_fire) begin
        reg_req.data <= wr_val;
      end
    end
  end

  // ------------------------------------------------------------
  // Buffer pointers
  // ------------------------------------------------------------

  logic rd_step;
  logic wr_step;
  logic [12:0] rd_ptr_next;
  logic [12:0] wr_ptr_next;

  assign rd_step = byte_done && (state_reg == scp_pkg::ST_RDBUF) && pointer_auto_step;
  assign wr_step = byte_done && (state_reg == scp_pkg::ST_WRBUF);

  // Ring end check comes before the plain roll-over
  assign rd_ptr_next = (buffer_read_pointer == rx_ring_end) ? rx_ring_start :
                       (buffer_read_pointer == `SCP_PTR_LAST) ? `SCP_PTR_ZERO :
                       buffer_read_pointer + `SCP_PTR_ONE;
  assign wr_ptr_next = (buffer_write_pointer == `SCP_PTR_LAST) ? `SCP_PTR_ZERO :
                       buffer_write_pointer + `SCP_PTR_ONE;

  // A software load beats an auto step in the same clock
  always_ff @(posedge clock) begin
    if (rst) begin
      buffer_read_pointer <= `SCP_PTR_ZERO;
    end else if (rd_ptr_load) begin
      buffer_read_pointer <= ptr_load_value;
    end else if (rd_step) begin
      buffer_read_pointer <= rd_ptr_next;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      buffer_write_pointer <= `SCP_PTR_ZERO;
    end else if (wr_ptr_load) begin
      buffer_write_pointer <= ptr_load_value;
    end else if (wr_step && pointer_auto_step) begin
      buffer_write_pointer <= wr_ptr_next;
    end
  end

  // Buffer store uses the pointer before its step
  always_ff @(posedge clock) begin
    if (rst) begin
      mem_req <= '0;
    end else begin
      mem_req.wr <= wr_step;
      if (wr_step) begin
        mem_req.addr <= buffer_write_pointer;
        mem_req.data <= byte_in;
      end
    end
  end

  // ------------------------------------------------------------
  // Soft reset
  // ------------------------------------------------------------

  // One clock pulse as soon as the full header is seen
  always_ff @(posedge clock) begin
    if (rst) begin
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= hdr_done && is_srst(byte_in);
    end
  end

endmodule

// File: verif/scp_spi_command_port_sva.sv
`timescale 1ns/100ps
// ----
// Port checker for the serial command port
// ----
module scp_spi_command_port_sva (
  input wire logic clock,
  input wire logic rst,
  input wire scp_pkg::scp_pins_t pins,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic pointer_auto_step,
  input wire logic [12:0] rx_ring_start,
  input wire logic [12:0] rx_ring_end,
  input wire logic rd_ptr_load,
  input wire scp_pkg::scp_reg_wr_t reg_req,
  input wire logic [12:0] buffer_read_pointer,
  input wire logic [12:0] buffer_write_pointer,
  input wire scp_pkg::scp_mem_wr_t mem_req,
  input wire logic soft_reset_pulse
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Quiet after reset; pointers start at zero
  rst_values_a: assert property (
    $fell(rst) |-> !so_oe && buffer_read_pointer == 13'h0000 && buffer_write_pointer == 13'h0000)
    else $error("outputs not quiet after reset");
  // Deselect releases the line within six clocks of chip select going high
  oe_idle_a: assert property (pins.cs_n [*6] |-> !so_oe)
    else $error("serial output driven while deselected");
  // Output bits move only while the pin clock is low, i.e. after a fall
  so_edge_a: assert property (
    so_oe && $past(so_oe) && $changed(so_out) |-> !$past(pins.sck, 2))
    else $error("serial output changed after a rising clock");
  wptr_step_a: assert property (
    mem_req.wr |-> buffer_write_pointer ==
      (pointer_auto_step ? 13'(mem_req.addr + 13'h1) : mem_req.addr))
    else $error("write pointer step wrong");
  // Read pointer moves only by load, ring wrap or single step
  rptr_step_a: assert property (
    !$past(rst) && !$past(rd_ptr_load) && $changed(buffer_read_pointer) |->
      pointer_auto_step && ($past(buffer_read_pointer) == rx_ring_end ?
      buffer_read_pointer == rx_ring_start :
      buffer_read_pointer == 13'($past(buffer_read_pointer) + 13'h1)))
    else $error("read pointer moved wrongly");
  reg_pulse_a: assert property (reg_req.wr |=> !reg_req.wr)
    else $error("register write longer than one cycle");
  mem_pulse_a: assert property (mem_req.wr |=> !mem_req.wr)
    else $error("memory write longer than one cycle");
  // A commit must follow a bit edge seen while still selected
  wr_cs_a: assert property (reg_req.wr || mem_req.wr |-> !$past(pins.cs_n, 4))
    else $error("commit after deselect");
  srst_pulse_a: assert property (
    soft_reset_pulse |-> !$past(pins.cs_n, 4) ##1 !soft_reset_pulse)
    else $error("soft reset pulse wrong");
  cover property (soft_reset_pulse);
  cover property (mem_req.wr);
  cover property ($rose(so_oe));
endmodule
bind scp_spi_command_port scp_spi_command_port_sva chk (.clock, .rst, .pins, .so_out, .so_oe,
  .pointer_auto_step, .rx_ring_start, .rx_ring_end, .rd_ptr_load, .reg_req,
  .buffer_read_pointer, .buffer_write_pointer, .mem_req, .soft_reset_pulse);

// File: verif/scp_host_model.sv
`timescale 1ns/100ps
// ----
// Host master: clock idles low, 160 ns bit period
// ----
module scp_host_model (
  input wire logic clock,
  input wire logic so_line,
  output scp_pkg::scp_pins_t pins
);
  initial begin
    pins = '{cs_n: 1'b1, sck: 1'b0, si: 1'b1};
  end
  // Select well ahead of the first rising clock
  task automatic frame_open();
    @(negedge clock);
    pins.cs_n = 1'b0;
    #80;
  endtask
  // Bits go out MSb first; the reply is taken at each rising clock
  task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      pins.si = tx[i];
      #80 pins.sck = 1'b1;
      rx[i] = so_line;
      #80 pins.sck = 1'b0;
    end
  endtask
  // Released data line flips so a stale level never looks valid
  task automatic frame_close();
    #80 pins.cs_n = 1'b1;
    pins.si = ~pins.si;
    #80;
  endtask
endmodule

// File: verif/test_spi_command_port.sv
`timescale 1ns/100ps
module test_spi_command_port;
  logic clock = 1'b0;
  logic rst = 1'b1;
  scp_pkg::scp_pins_t pins;
  logic so_out;
  logic so_oe;
  logic pointer_auto_step = 1'b1;
  logic [12:0] rx_ring_start = 13'h0000;
  logic [12:0] rx_ring_end = 13'h1000;
  logic rd_ptr_load = 1'b0;
  logic wr_ptr_load = 1'b0;
  logic [12:0] ptr_load_value = 13'h0000;
  scp_pkg::scp_reg_wr_t reg_req;
  scp_pkg::scp_mem_wr_t mem_req;
  logic [12:0] buffer_read_pointer;
  logic [12:0] buffer_write_pointer;
  logic soft_reset_pulse;
  logic [7:0] regs [32];
  logic [7:0] mem [8192];
  logic [7:0] r0;
  logic [7:0] r1;
  int num_errors = 0;
  int n_compared = 0;
  int n_regwr = 0;
  int n_srst = 0;
  int n;
  always #4 clock = ~clock;
  // ----
  // Far side: line level, register file and packet memory
  // ----
  wire logic so_line = so_oe ? so_out : 1'bz;
  wire logic reg_core_sel = reg_req.addr[4]; // Upper half of the bank is core group
  wire logic [7:0] reg_rdata = regs[reg_req.addr];
  wire logic [7:0] mem_rdata = mem[buffer_read_pointer];
  initial begin
    foreach (regs[i]) regs[i] = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  always @(posedge clock) begin
    if (reg_req.wr === 1'b1) begin
      regs[reg_req.addr] <= reg_req.data;
      n_regwr++;
    end
    if (mem_req.wr === 1'b1) mem[mem_req.addr] <= mem_req.data;
    if (soft_reset_pulse === 1'b1) n_srst++;
  end
  scp_host_model host (.clock, .so_line, .pins);
  scp_spi_command_port dut (.clock, .rst, .pins, .so_out, .so_oe, .pointer_auto_step,
    .rx_ring_start, .rx_ring_end, .rd_ptr_load, .wr_ptr_load, .ptr_load_value, .reg_core_sel,
    .reg_rdata, .reg_req, .buffer_read_pointer, .buffer_write_pointer, .mem_rdata, .mem_req,
    .soft_reset_pulse);
  // ----
  // Access tasks and comparisons
  // ----
  task automatic xact(input logic [7:0] hdr, input logic [7:0] d0, input logic [7:0] d1,
                      input int nb);
    logic [7:0] junk;
    host.frame_open();
    host.shift(hdr, 8, junk);
    if (nb > 0) host.shift(d0, (nb > 8) ? 8 : nb, r0);
    if (nb > 8) host.shift(d1, nb - 8, r1);
    host.frame_close();
  endtask
  task automatic load_ptr(input logic rd, input logic [12:0] v);
    @(negedge clock);
    ptr_load_value = v;
    rd_ptr_load = rd;
    wr_ptr_load = !rd;
    @(negedge clock);
    rd_ptr_load = 1'b0;
    wr_ptr_load = 1'b0;
  endtask
  task automatic note(input logic ok, input string what);
    n_compared++;
    if (!ok) begin
      num_errors++;
      $display("BAD at %0t: %s", $time, what);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    note(got === exp, "byte mismatch");
  endtask
  task automatic chk_ptr(input logic [12:0] got, input logic [12:0] exp);
    note(got === exp, "pointer mismatch");
  endtask
  task automatic chk_cnt(input int got, input int exp);
    note(got == exp, "count mismatch");
  endtask
  task automatic final_report();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Stuck transfers are cut short well past the expected run time
  initial begin
    #200000;
    num_errors++;
    $display("BAD at %0t: watchdog expired", $time);
    final_report();
  end
  // ----
  // Test sequence
  // ----
  initial begin
    repeat (5) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    xact(8'h4a, 8'h5c, 8'h00, 8);
    chk_byte(regs[5'h0a], 8'h5c);
    xact(8'h4a, 8'h33, 8'h00, 5);
    chk_byte(regs[5'h0a], 8'h5c);
    xact(8'h5c, 8'ha5, 8'h00, 8);
    xact(8'h1c, 8'h00, 8'h00, 16);
    chk_byte(r0, 8'ha5);
    chk_byte(r1, 8'ha5);
    xact(8'h0a, 8'h00, 8'h00, 16);
    chk_byte(r0, 8'h00);
    chk_byte(r1, 8'h5c);
    xact(8'h1c, 8'h00, 8'h00, 3);
    xact(8'h1c, 8'h00, 8'h00, 8);
    chk_byte(r0, 8'ha5);
    xact(8'h9c, 8'h0f, 8'h00, 8);
    chk_byte(regs[5'h1c], 8'haf);
    xact(8'hbc, 8'h17, 8'h00, 8);
    chk_byte(regs[5'h1c], 8'ha8);
    xact(8'h8a, 8'hff, 8'h00, 8);
    chk_byte(regs[5'h0a], 8'h5c);
    // Unassigned opcode and wrong constants must leave everything alone
    n = n_regwr;
    xact(8'hdc, 8'h55, 8'h00, 8);
    xact(8'h7b, 8'h55, 8'h00, 8);
    chk_cnt(n_regwr, n);
    chk_ptr(buffer_write_pointer, 13'h0000);
    xact(8'hfe, 8'h00, 8'h00, 0);
    chk_cnt(n_srst, 0);
    xact(8'hff, 8'h00, 8'h00, 0);
    chk_cnt(n_srst, 1);
    load_ptr(1'b0, 13'h1fff);
    xact(8'h7a, 8'h11, 8'h22, 16);
    chk_byte(mem[13'h1fff], 8'h11);
    chk_byte(mem[13'h0000], 8'h22);
    chk_ptr(buffer_write_pointer, 13'h0001);
    load_ptr(1'b1, 13'h1fff);
    xact(8'h3a, 8'h00, 8'h00, 16);
    chk_byte(r0, 8'h11);
    chk_byte(r1, 8'h22);
    chk_ptr(buffer_read_pointer, 13'h0001);
    rx_ring_end = 13'h0000;
    rx_ring_start = 13'h1fff;
    load_ptr(1'b1, 13'h0000);
    xact(8'h3a, 8'h00, 8'h00, 16);
    chk_byte(r0, 8'h22);
    chk_byte(r1, 8'h11);
    chk_ptr(buffer_read_pointer, 13'h0000);
    pointer_auto_step = 1'b0;
    xact(8'h3a, 8'h00, 8'h00, 16);
    chk_byte(r1, 8'h22);
    chk_ptr(buffer_read_pointer, 13'h0000);
    // Buffer store without auto step keeps the write pointer in place
    xact(8'h7a, 8'h44, 8'h00, 8);
    chk_byte(mem[13'h0001], 8'h44);
    chk_ptr(buffer_write_pointer, 13'h0001);
    final_report();
  end
endmodule
